// [sirq_agent.sv]
// Peripheral agent for the shared serial interrupt line.
// Assumes link_clk is the line's free-running bus clock and that the pin
// pad resolves the open-drain wire from the output and enable here.
`timescale 1ns/10ps
// Functional notes
// - Shared open-drain line, driven on link clock
// - Cycle: start, IRQ/Data frames, one stop
// - Quiet start: pull low one clock, release
// - Continuous mode: host alone starts cycles
// - Reset selects Continuous mode
// - Frame counting starts at start's rising edge
// - Frame is sample, recovery, turn-around clocks
// - Active request pulls sample low, else undriven
// - Recovery clock after own sample: drive high
// - Turn-around clock: release the line
// - Drive only channels 3,4,5,9,10,11
// - Channels 3-5 sample at 11,14,17
// - Channels 9-11 sample at 29,32,35
// - Fixed frame order; frames 22-32 never driven
// - Two-clock stop selects Quiet mode
// - Three-clock stop selects Continuous mode
// - All requests leave only via serial line
// - Gate bit 0 forces port request inactive
module sirq_agent
    import sirq_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic [NUM_PORT-1:0] port_req,
    input wire logic [NUM_PORT-1:0] port_gate,
    input wire logic [NUM_PORT*CHAN_W-1:0] port_chan,
    input wire logic shared_interrupt_pin_i,
    output logic shared_interrupt_pin_o,
    output logic shared_interrupt_pin_oe
);
    // Channel levels on the system clock.
    sirq_chan_if chan_bus ();
    // Channel levels after the crossing into the link domain.
    logic [NUM_CHAN-1:0] lvl_s;
    // Line level after the two-flop synchroniser.
    logic lin_s;
    // Reset carried into the link domain.
    logic lrst;

    // Routing of port requests onto channels, on the system clock.
    sirq_src_map u_map (
        .clk(clk),
        .rst(rst),
        .port_req(port_req),
        .port_gate(port_gate),
        .port_chan(port_chan),
        .chan(chan_bus.src)
    );

    // Channel levels cross as independent levels.
    sirq_sync #(.W(NUM_CHAN)) u_lvl_sync (
        .clk(link_clk),
        .d(chan_bus.level),
        .q(lvl_s)
    );

    // The pin comes from outside the domain and passes two flops.
    sirq_sync #(.W(1)) u_pin_sync (
        .clk(link_clk),
        .d(shared_interrupt_pin_i),
        .q(lin_s)
    );

    // Reset is a level and crosses the same way.
    sirq_sync #(.W(1)) u_rst_sync (
        .clk(link_clk),
        .d(rst),
        .q(lrst)
    );

    // Link state.
    sirq_state_t st_r;
    sirq_state_t st_nxt;
    // Clocks past the start pulse's rising edge, valid in frames state.
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    // Length of the current or just-ended low run of the line.
    logic [RUN_W-1:0] run_r;
    logic [RUN_W-1:0] run_nxt;
    // Synchronised line level one clock earlier, for edge detection.
    logic lin_prev_r;
    // Mode for the next cycle: 1 is Continuous, 0 is Quiet.
    logic mode_cont_r;
    logic mode_cont_nxt;
    // Levels latched at the start of the cycle being reported.
    logic [NUM_CHAN-1:0] lat_r;
    logic [NUM_CHAN-1:0] lat_nxt;
    // Levels last reported, for change detection in Quiet mode.
    logic [NUM_CHAN-1:0] rep_r;
    logic [NUM_CHAN-1:0] rep_nxt;
    // High in the one clock in which this agent pulls a Quiet start.
    logic q_start_r;
    logic q_start_nxt;
    // Pin output and output enable registers.
    logic pin_o_r;
    logic pin_o_nxt;
    logic pin_oe_r;
    logic pin_oe_nxt;

    // A rising edge of the line, seen two clocks late.
    logic rise;
    // A rise that ends a start pulse long enough to open a cycle.
    logic start_rise;
    // A rise that ends a stop pulse.
    logic stop_rise;
    // The next clock is a sample clock of channel k.
    logic [NUM_CHAN-1:0] slot_next;
    // This clock is a sample clock of channel k.
    logic [NUM_CHAN-1:0] slot_now;
    // This agent is pulling the line low in a sample clock now.
    logic own_low;

    assign rise = lin_s && !lin_prev_r;
    assign start_rise = rise && (st_r != ST_FRAMES) && (run_r >= START_MIN_LOW);
    assign stop_rise = rise && (st_r == ST_STOP) &&
        (run_r == STOP_QUIET_LOW || run_r == STOP_CONT_LOW);
    assign own_low = pin_oe_r && !pin_o_r && !q_start_r;

    // Decodes the sample positions of each served channel; no other frame
    // position is ever decoded, so no other frame can be driven.
    for (genvar k = 0; k < NUM_CHAN; k++) begin : g_slot
        // Sample points 11, 14, 17, 29, 32, 35 past the start.
        assign slot_next[k] = (st_r == ST_FRAMES) &&
            (cnt_r + 7'h01 == sample_pt(k));
        assign slot_now[k] = (st_r == ST_FRAMES) && (cnt_r == sample_pt(k));
    end

    // Next-state logic for the link state, counters, mode and latches.
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        mode_cont_nxt = mode_cont_r;
        lat_nxt = lat_r;
        rep_nxt = rep_r;
        q_start_nxt = 1'b0;
        // Counts low clocks, saturating; a high clock clears the run.
        if (lin_s) begin
            run_nxt = '0;
        end else if (run_r != RUN_MAX) begin
            run_nxt = run_r + 4'h1;
        end else begin
            run_nxt = run_r;
        end
        // The frames phase counts clocks from the start pulse's rise,
        // whoever pulled the start.
        if (start_rise) begin
            st_nxt = ST_FRAMES;
            cnt_nxt = SYNC_LAT;
            // Levels reported in this cycle are frozen here.
            lat_nxt = lvl_s;
            rep_nxt = lvl_s;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    // Only in Quiet mode, with the line idle and a level
                    // changed, does this agent open a cycle.
                    if (!mode_cont_r && lin_s && lin_prev_r && !pin_oe_r &&
                        lvl_s != rep_r) begin
                        q_start_nxt = 1'b1;
                        st_nxt = ST_START;
                    end
                end
                ST_START: begin
                    // A short run after our pulse means the host did not
                    // take over; fall back and try again later.
                    if (rise) begin
                        st_nxt = ST_IDLE;
                    end
                end
                ST_FRAMES: begin
                    // Three clocks a frame; leave after the last owned
                    // frame's turn-around.
                    if (cnt_r == FRAMES_END) begin
                        st_nxt = ST_STOP;
                    end else begin
                        cnt_nxt = cnt_r + 7'h01;
                    end
                end
                ST_STOP: begin
                    // Single-clock lows are other agents' samples; the
                    // host's stop pulse picks the next mode.
                    if (stop_rise) begin
                        st_nxt = ST_IDLE;
                        // Two clocks low: Quiet; three: Continuous.
                        mode_cont_nxt = (run_r == STOP_CONT_LOW);
                    end
                end
                default: begin
                    st_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // Registers the link state; reset leaves Continuous mode selected.
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            st_r <= ST_IDLE;
            cnt_r <= '0;
            run_r <= '0;
            lin_prev_r <= 1'b1;
            // The host opens the first cycle.
            mode_cont_r <= MODE_CONT_RST;
            lat_r <= '0;
            rep_r <= '0;
            q_start_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
            lin_prev_r <= lin_s;
            mode_cont_r <= mode_cont_nxt;
            lat_r <= lat_nxt;
            rep_r <= rep_nxt;
            q_start_r <= q_start_nxt;
        end
    end

    // Next pin drive: low for a Quiet start or an active sample, high in
    // the recovery clock after our own low sample, released otherwise.
    always_comb begin
        pin_oe_nxt = 1'b0;
        pin_o_nxt = 1'b0;
        if (q_start_nxt) begin
            // One clock low, then released by default.
            pin_oe_nxt = 1'b1;
        end else if (|(slot_next & lat_r)) begin
            // Active channel pulls its sample clock low.
            pin_oe_nxt = 1'b1;
        end else if (|slot_now && own_low) begin
            // Recovery: drive high for one clock.
            pin_oe_nxt = 1'b1;
            pin_o_nxt = 1'b1;
        end
        // Every other clock, turn-around included, leaves the line free.
    end

    // Pin registers; the line is released under reset.
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            pin_oe_r <= 1'b0;
            pin_o_r <= 1'b0;
        end else begin
            pin_oe_r <= pin_oe_nxt;
            pin_o_r <= pin_o_nxt;
        end
    end

    // The line is the only interrupt path out of the block.
    assign shared_interrupt_pin_o = pin_o_r;
    assign shared_interrupt_pin_oe = pin_oe_r;

    // All checks below sample on the link clock; all but chk_reset_mode pause under reset.
    default clocking cb @(posedge link_clk);
    endclocking
    default disable iff (lrst);

    // Our own low sample clock.
    sequence s_own_sample;
        pin_oe_r && !pin_o_r && !q_start_r;
    endsequence

    // One clock driven high, then released.
    sequence s_recover_release;
        pin_oe_r && pin_o_r ##1 !pin_oe_r;
    endsequence

    // A Quiet start is low for exactly one clock.
    sequence s_quiet_pulse;
        pin_oe_r && !pin_o_r ##1 !pin_oe_r;
    endsequence

    property p_recovery;
        s_own_sample |=> s_recover_release;
    endproperty

    property p_quiet_pulse;
        q_start_r |-> s_quiet_pulse;
    endproperty

    chk_quiet_pulse : assert property (p_quiet_pulse)
        else $error("Quiet start pulse is not a single low clock.");

    chk_no_cont_start : assert property (q_start_r |-> !$past(mode_cont_r))
        else $error("Agent pulled a start in Continuous mode.");

    chk_reset_mode : assert property (disable iff (1'b0)
        $fell(lrst) |-> mode_cont_r && st_r == ST_IDLE)
        else $error("Mode after reset is not Continuous.");

    chk_frame_start : assert property (start_rise |=>
        st_r == ST_FRAMES && cnt_r == SYNC_LAT)
        else $error("Frame count did not restart at the start rise.");

    chk_own_slot : assert property (s_own_sample |->
        st_r == ST_FRAMES && |slot_now)
        else $error("Line driven low outside an owned sample clock.");

    chk_sample_low : assert property (|(slot_next & lat_r) |=>
        pin_oe_r && !pin_o_r)
        else $error("Active channel did not pull its sample clock low.");

    chk_recovery : assert property (p_recovery)
        else $error("Recovery high or turn-around release missing.");

    chk_latch : assert property (start_rise |=> lat_r == $past(lvl_s))
        else $error("Levels not latched at cycle start.");

    chk_stop_quiet : assert property (stop_rise && run_r == STOP_QUIET_LOW
        |=> !mode_cont_r && st_r == ST_IDLE)
        else $error("Two-clock stop did not select Quiet mode.");

    chk_stop_cont : assert property (stop_rise && run_r == STOP_CONT_LOW
        |=> mode_cont_r && st_r == ST_IDLE)
        else $error("Three-clock stop did not select Continuous mode.");

    chk_start_cause : assert property (q_start_r |->
        $past(lvl_s != rep_r) && $past(lin_s))
        else $error("Quiet start without idle line and changed level.");
endmodule

// [sirq_pkg.sv]
// Package for the serial interrupt peripheral agent: channel map, frame timing,
// low-run lengths, reset values and the link state type.
// Assumes the link side runs on the shared line's own clock.
package sirq_pkg;

    // Number of interrupt channels this agent reports on.
    localparam int NUM_CHAN = 6;
    // Number of serial ports whose requests are routed onto the channels.
    localparam int NUM_PORT = 4;
    // Width of a port's channel select field.
    localparam int CHAN_W = 4;
    // Width of the frame position counter.
    localparam int CNT_W = 7;
    // Width of the low-run counter.
    localparam int RUN_W = 4;

    // Interrupt numbers served, in channel order.
    localparam logic [CHAN_W-1:0] CHAN_NUM [0:NUM_CHAN-1] =
        '{4'h3, 4'h4, 4'h5, 4'h9, 4'ha, 4'hb};
    // IRQ/Data frame number that carries each channel.
    localparam int CHAN_FRAME [0:NUM_CHAN-1] = '{4, 5, 6, 10, 11, 12};
    // Clocks past the start pulse's rising edge of the first sample phase.
    localparam int FIRST_SAMPLE = 2;
    // Clocks in one IRQ/Data frame: sample, recovery, turn-around.
    localparam int FRAME_CLKS = 3;

    // Sample point of channel k, in clocks past the start pulse's rising edge.
    function automatic logic [CNT_W-1:0] sample_pt(input int k);
        return CNT_W'(FIRST_SAMPLE + FRAME_CLKS * (CHAN_FRAME[k] - 1));
    endfunction

    // Counter value in the first cycle after a rise is seen: one register
    // stage plus two synchroniser stages behind the line.
    localparam logic [CNT_W-1:0] SYNC_LAT = 7'h03;
    // Position of the last owned frame's turn-around clock.
    localparam logic [CNT_W-1:0] FRAMES_END =
        CNT_W'(FIRST_SAMPLE + FRAME_CLKS * CHAN_FRAME[NUM_CHAN-1] - 1);
    // Shortest low run that counts as a start pulse.
    localparam logic [RUN_W-1:0] START_MIN_LOW = 4'h4;
    // Stop pulse length that selects Quiet mode.
    localparam logic [RUN_W-1:0] STOP_QUIET_LOW = 4'h2;
    // Stop pulse length that selects Continuous mode.
    localparam logic [RUN_W-1:0] STOP_CONT_LOW = 4'h3;
    // Saturation value of the low-run counter.
    localparam logic [RUN_W-1:0] RUN_MAX = 4'hf;
    // Mode after reset: Continuous.
    localparam logic MODE_CONT_RST = 1'b1;

    // Link states, Gray coded along idle, start, frames, stop.
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_START  = 2'b01,
        ST_FRAMES = 2'b11,
        ST_STOP   = 2'b10
    } sirq_state_t;

endpackage

// [sirq_chan_if.sv]
// Interface carrying the per-channel request levels from the routing logic
// to the link agent. Levels are registered on the system clock.
`timescale 1ns/10ps
interface sirq_chan_if;
    import sirq_pkg::*;
    // One request level per served channel.
    logic [NUM_CHAN-1:0] level;
    // Routing side drives the levels.
    modport src (output level);
    // Agent side reads them and must synchronise them first.
    modport dst (input level);
endinterface

// [sirq_sync.sv]
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a level that stays put for several destination clocks.
`timescale 1ns/10ps
module sirq_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // First stage; read only by the second stage.
    logic [W-1:0] meta_r;
    // Second stage; the only one other logic may read.
    logic [W-1:0] sync_r;

    // Each bit passes two flops on the destination clock.
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk) begin
            meta_r[i] <= d[i];
            sync_r[i] <= meta_r[i];
        end
    end

    assign q = sync_r;
endmodule

// [sirq_src_map.sv]
// Routes each serial port's interrupt request onto its selected channel.
// Assumes requests, gate bits and channel selects come from system-clock logic.
`timescale 1ns/10ps
module sirq_src_map
    import sirq_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [NUM_PORT-1:0] port_req,
    input wire logic [NUM_PORT-1:0] port_gate,
    input wire logic [NUM_PORT*CHAN_W-1:0] port_chan,
    sirq_chan_if.src chan
);
    // Registered channel levels, launched from flops for the crossing.
    logic [NUM_CHAN-1:0] level_r;
    // Next channel levels.
    logic [NUM_CHAN-1:0] level_nxt;

    // A channel is active when any gated, requesting port selects it; a select that
    // names no served channel reaches nothing.
    for (genvar k = 0; k < NUM_CHAN; k++) begin : g_chan
        always_comb begin
            level_nxt[k] = 1'b0;
            for (int p = 0; p < NUM_PORT; p++) begin
                // A port whose gate bit is 0 never asserts.
                if (port_gate[p] && port_req[p] &&
                    port_chan[p*CHAN_W +: CHAN_W] == CHAN_NUM[k]) begin
                    level_nxt[k] = 1'b1;
                end
            end
        end
    end

    // Registers the levels; cleared by reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            level_r <= '0;
        end else begin
            level_r <= level_nxt;
        end
    end

    assign chan.level = level_r;

    // With every gate bit closed, no channel may show a request.
    chk_gate_off : assert property (@(posedge clk) disable iff (rst)
        port_gate == '0 |=> level_r == '0)
        else $error("Channel active while all gate bits are closed.");
endmodule

// [sirq_host.sv]
// Host controller model for the shared serial interrupt line.
// Assumes the agent's drive value and enable are registers on link_clk.
`timescale 1ns/10ps
module sirq_host (
    input wire logic link_clk,
    input wire logic agent_o,
    input wire logic agent_oe,
    output logic line
);
    // Host drive value and enable.
    logic ho;
    logic hoe;
    // Agent {enable, drive high} seen at each clock past the start's rise.
    logic [1:0] seen [0:99];
    // Set when the agent's one-clock quiet pull was seen.
    logic got;
    // Agent enable in the clock after its quiet pull.
    logic q_after;
    // Clocks in which the agent drove while the line was watched idle.
    // Four-state, so that an unknown enable cannot pass as zero.
    logic [31:0] drives;

    // Open-drain wire with a pull-up: any low driver wins.
    assign line = ~((agent_oe & ~agent_o) | (hoe & ~ho));

    // The host starts released.
    initial begin
        ho = 1'b1;
        hoe = 1'b0;
    end

    // One full cycle: start, 100 clocks past the rise recorded, then a stop of stop_len clocks.
    task automatic run_cycle(input int low_len, input int stop_len, input bit quiet);
        got = 1'b0;
        q_after = 1'b0;
        if (quiet) begin
            // Wait for the agent's pull, then carry the low on to low_len.
            for (int n = 0; n < 60 && !got; n++) begin
                @(posedge link_clk);
                got = agent_oe & ~agent_o;
            end
            hoe <= 1'b1;
            ho <= 1'b0;
            @(posedge link_clk);
            q_after = agent_oe;
            repeat (low_len - 2) @(posedge link_clk);
        end else begin
            // Only the host opens a cycle in Continuous mode.
            @(posedge link_clk);
            hoe <= 1'b1;
            ho <= 1'b0;
            repeat (low_len) @(posedge link_clk);
        end
        // High for one clock, then released.
        ho <= 1'b1;
        for (int p = 0; p < 100; p++) begin
            @(posedge link_clk);
            if (p == 0) begin
                hoe <= 1'b0;
            end
            seen[p] = {agent_oe, agent_oe & agent_o};
        end
        // Stop: two clocks low selects Quiet, three Continuous.
        hoe <= 1'b1;
        ho <= 1'b0;
        repeat (stop_len) @(posedge link_clk);
        hoe <= 1'b0;
        repeat (4) @(posedge link_clk);
    endtask

    // Counts the clocks in which the agent drives an idle line.
    task automatic idle_watch(input int n);
        drives = '0;
        repeat (n) begin
            @(posedge link_clk);
            drives += 32'(agent_oe);
        end
    endtask
endmodule

// [serial_irq_peripheral_agent_tb.sv]
// Self-checking bench for the serial interrupt peripheral agent.
// Assumes sirq_host plays the chipset side and link_clk runs freely.
`timescale 1ns/10ps
module serial_irq_peripheral_agent_tb;
    import sirq_pkg::*;
    logic clk;
    logic rst;
    logic link_clk;
    logic [NUM_PORT-1:0] port_req;
    logic [NUM_PORT-1:0] port_gate;
    logic [NUM_PORT*CHAN_W-1:0] port_chan;
    logic line;
    logic pin_o;
    logic pin_oe;
    int bad_count;
    int samples_checked;
    // One row: requests, gates, channel selects and expected channel mask.
    typedef struct {
        logic [3:0] req;
        logic [3:0] gate;
        logic [15:0] chan;
        logic [5:0] mask;
    } sirq_row_t;
    sirq_row_t rows [0:6] = '{
        '{4'h1, 4'h1, 16'h0003, 6'h01},
        '{4'hf, 4'hf, 16'ha954, 6'h1e},
        '{4'h3, 4'h3, 16'h00b3, 6'h21},
        '{4'hf, 4'h0, 16'hba93, 6'h00},
        '{4'hf, 4'hf, 16'h072c, 6'h00},
        '{4'h5, 4'hf, 16'h3333, 6'h01},
        '{4'hf, 4'ha, 16'hba54, 6'h24}
    };

    sirq_agent sirq_agent_i (
        .clk(clk),
        .rst(rst),
        .link_clk(link_clk),
        .port_req(port_req),
        .port_gate(port_gate),
        .port_chan(port_chan),
        .shared_interrupt_pin_i(line),
        .shared_interrupt_pin_o(pin_o),
        .shared_interrupt_pin_oe(pin_oe)
    );

    sirq_host sirq_host_i (
        .link_clk(link_clk),
        .agent_o(pin_o),
        .agent_oe(pin_oe),
        .line(line)
    );

    // System clock, 50 ns period.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Line clock, 64 ns period, offset so its edges drift against clk.
    initial begin
        link_clk = 1'b0;
        #13;
        forever #32 link_clk = ~link_clk;
    end

    // Counts a comparison and reports a mismatch at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Sets one row on the inputs, then lets it settle for n system clocks.
    task automatic apply(input sirq_row_t r, input int n);
        @(negedge clk);
        port_req = r.req;
        port_gate = r.gate;
        port_chan = r.chan;
        repeat (n) @(negedge clk);
    endtask

    // Compares every recorded position with the drive the mask asks for.
    task automatic check_frames(input logic [5:0] mask);
        logic [1:0] exp;
        for (int p = 0; p < 100; p++) begin
            exp = 2'b00;
            for (int k = 0; k < NUM_CHAN; k++) begin
                if (mask[k] && p == 2 + 3 * (CHAN_FRAME[k] - 1)) begin
                    exp = 2'b10;
                end
                if (mask[k] && p == 3 + 3 * (CHAN_FRAME[k] - 1)) begin
                    exp = 2'b11;
                end
            end
            check(32'(sirq_host_i.seen[p]), 32'(exp));
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence: reset, table rows, then mode changes.
    initial begin
        bad_count = 0;
        samples_checked = 0;
        rst = 1'b1;
        port_req = '0;
        port_gate = '0;
        port_chan = '0;
        repeat (6) @(negedge clk);
        check(32'({pin_oe, pin_o}), 32'h0000_0000);
        rst = 1'b0;
        // A live request after reset must wait for the host.
        apply(rows[0], 10);
        sirq_host_i.idle_watch(40);
        check(32'(sirq_host_i.drives), 32'h0000_0000);
        // Each row in a host-started cycle, start low for 4 to 8 clocks.
        foreach (rows[i]) begin
            apply(rows[i], 10);
            sirq_host_i.run_cycle(4 + i % 5, 3, 1'b0);
            check_frames(rows[i].mask);
        end
        // A two-clock stop leaves the agent free to start on a change.
        sirq_host_i.run_cycle(4, 2, 1'b0);
        check_frames(rows[6].mask);
        apply(rows[1], 1);
        sirq_host_i.run_cycle(4, 2, 1'b1);
        check(32'(sirq_host_i.got), 32'h0000_0001);
        check(32'(sirq_host_i.q_after), 32'h0000_0000);
        check_frames(rows[1].mask);
        // Unchanged levels in Quiet mode leave the line alone.
        sirq_host_i.idle_watch(40);
        check(32'(sirq_host_i.drives), 32'h0000_0000);
        apply(rows[2], 1);
        sirq_host_i.run_cycle(8, 3, 1'b1);
        check(32'(sirq_host_i.got), 32'h0000_0001);
        check_frames(rows[2].mask);
        // After a three-clock stop a change starts nothing.
        apply(rows[0], 10);
        sirq_host_i.idle_watch(40);
        check(32'(sirq_host_i.drives), 32'h0000_0000);
        sirq_host_i.run_cycle(4, 3, 1'b0);
        check_frames(rows[0].mask);
        // A reset taken in Quiet mode must bring Continuous mode back.
        sirq_host_i.run_cycle(5, 2, 1'b0);
        check_frames(rows[0].mask);
        @(negedge clk);
        rst = 1'b1;
        repeat (6) @(negedge clk);
        check(32'({pin_oe, pin_o}), 32'h0000_0000);
        rst = 1'b0;
        // A changed level after this reset must still wait for the host.
        apply(rows[1], 10);
        sirq_host_i.idle_watch(40);
        check(32'(sirq_host_i.drives), 32'h0000_0000);
        sirq_host_i.run_cycle(6, 3, 1'b0);
        check_frames(rows[1].mask);
        final_report;
    end
endmodule
